//--- hdl/ipei_pkg.sv
// Constants for the ID pin event interrupt block
package ipei_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] ID_EVENT_ENABLE_WR  = 6'h1D;
  localparam logic [5:0] ID_EVENT_ENABLE_SET = 6'h1E;
  localparam logic [5:0] ID_EVENT_ENABLE_CLR = 6'h1F;
  localparam logic [5:0] ID_EVENT_STATUS     = 6'h20;
  localparam logic [5:0] ID_EVENT_LATCH      = 6'h21;

  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int         OPEN_RISE_BIT  = 0;
  localparam int         OPEN_FALL_BIT  = 1;
  localparam int         DONE_EN_BIT    = 5;
  localparam int         STAT_OPEN_BIT  = 0;
  localparam int         STAT_CODE_LSB  = 3;
  localparam int         STAT_DONE_BIT  = 6;
  localparam int         LATCH_OPEN_BIT = 0;
  localparam int         LATCH_DONE_BIT = 3;
  localparam logic [7:0] ENABLE_MASK    = 8'h23;
  localparam logic [7:0] LATCH_MASK     = 8'h09;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [2:0] CODE_RESET     = 3'h0;

  // ----------------------------------------------------------------
  // Resistance result codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CODE_ZERO_OHM = 3'h0;
  localparam logic [2:0] CODE_75_OHM   = 3'h1;
  localparam logic [2:0] CODE_102K_OHM = 3'h2;
  localparam logic [2:0] CODE_200K_OHM = 3'h3;
  localparam logic [2:0] CODE_440K_OHM = 3'h4;
  localparam logic [2:0] CODE_FLOATING = 3'h5;
  localparam logic [2:0] CODE_UNUSED   = 3'h6;
  localparam logic [2:0] CODE_ERROR    = 3'h7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_TIME_NS  = 282000;
  localparam int CONV_CYCLES   =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

//--- hdl/ipei_core.sv
// ID pin event enable, status and latch registers with alt_int report
`timescale 1ns/100ps
`default_nettype none

module ipei_core #(
  parameter int CONV_CYCLES = ipei_pkg::CONV_CYCLES
) (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_b_in,
  // Register port
  input  wire logic [5:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  // ID pin and pull-up state
  input  wire logic       id_open_in,
  input  wire logic       id_pullup_enable_in,
  // Resistance converter
  input  wire logic       conv_start_in,
  input  wire logic [2:0] id_resistance_code_in,
  input  wire logic       vendor_done_irq_en_in,
  input  wire logic       vendor_code_read_in,
  // Event report to RXCMD
  output logic            alt_int_out
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_bad_conv
    $error("CONV_CYCLES must lie in 1..65535");
  end

  localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);

  logic [7:0]  enable_ff;
  logic [7:0]  latch_ff;
  logic [2:0]  code_ff;
  logic        done_ff;
  logic        done_prev_ff;
  logic        busy_ff;
  logic [15:0] conv_cnt_ff;
  logic        id_meta_ff;
  logic        id_sync_ff;
  logic        id_prev_ff;
  logic        pullup_meta_ff;
  logic        pullup_sync_ff;
  logic        open_rise;
  logic        open_fall;
  logic        done_rise;
  logic        done_irq_en;
  logic        latch_read;
  logic [7:0]  status_val;
  logic [7:0]  nxt_rdata;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two stages before anything looks at the pins
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      id_meta_ff     <= 1'b0;
      id_sync_ff     <= 1'b0;
      id_prev_ff     <= 1'b0;
      pullup_meta_ff <= 1'b0;
      pullup_sync_ff <= 1'b0;
    end else begin
      id_meta_ff     <= id_open_in;
      id_sync_ff     <= id_meta_ff;
      id_prev_ff     <= id_sync_ff;
      pullup_meta_ff <= id_pullup_enable_in;
      pullup_sync_ff <= pullup_meta_ff;
    end
  end

  // Edge terms compare synced and one-older sample only
  assign open_rise   = id_sync_ff & ~id_prev_ff;
  assign open_fall   = ~id_sync_ff & id_prev_ff;
  assign done_rise   = done_ff & ~done_prev_ff;
  assign done_irq_en = enable_ff[ipei_pkg::DONE_EN_BIT]
                       | vendor_done_irq_en_in;
  assign latch_read  = reg_rd_in && reg_addr_in == ipei_pkg::ID_EVENT_LATCH;

  // ----------------------------------------------------------------
  // Enable register
  // ----------------------------------------------------------------
  // Only bits 0, 1 and 5 are storage; the rest stay zero
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      enable_ff <= ipei_pkg::REG_RESET;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        ipei_pkg::ID_EVENT_ENABLE_WR:
          enable_ff <= reg_wdata_in & ipei_pkg::ENABLE_MASK;
        ipei_pkg::ID_EVENT_ENABLE_SET:
          enable_ff <= (enable_ff | reg_wdata_in)
                       & ipei_pkg::ENABLE_MASK;
        ipei_pkg::ID_EVENT_ENABLE_CLR:
          enable_ff <= enable_ff & ~reg_wdata_in;
        default: enable_ff <= enable_ff;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Resistance conversion timer and result
  // ----------------------------------------------------------------
  // A start during a running conversion is ignored, not restarted
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_ff     <= 1'b0;
      conv_cnt_ff <= 16'h0000;
      code_ff     <= ipei_pkg::CODE_RESET;
    end else if (busy_ff) begin
      if (conv_cnt_ff == 16'h0000) begin
        busy_ff <= 1'b0;
        code_ff <= id_resistance_code_in;
      end else begin
        conv_cnt_ff <= conv_cnt_ff - 16'h0001;
      end
    end else if (conv_start_in) begin
      busy_ff     <= 1'b1;
      conv_cnt_ff <= CONV_LAST;
    end
  end

  // Done flag: completion wins over a same-cycle vendor read
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      done_ff      <= 1'b0;
      done_prev_ff <= 1'b0;
    end else begin
      done_prev_ff <= done_ff;
      if (busy_ff && conv_cnt_ff == 16'h0000) begin
        done_ff <= 1'b1;
      end else if (vendor_code_read_in) begin
        done_ff <= 1'b0;
      end
    end
  end

  localparam int LATCH_OPEN_IDX = ipei_pkg::LATCH_OPEN_BIT;
  localparam int LATCH_DONE_IDX = ipei_pkg::LATCH_DONE_BIT;

  // ----------------------------------------------------------------
  // Latch register
  // ----------------------------------------------------------------
  // Set beats clear so an event during the read is kept
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      latch_ff <= ipei_pkg::REG_RESET;
    end else begin
      latch_ff[LATCH_OPEN_IDX] <=
        (open_rise & enable_ff[ipei_pkg::OPEN_RISE_BIT])
        | (open_fall & enable_ff[ipei_pkg::OPEN_FALL_BIT])
        | (latch_ff[LATCH_OPEN_IDX] & ~latch_read);
      latch_ff[LATCH_DONE_IDX] <= (done_rise & done_irq_en)
        | (latch_ff[LATCH_DONE_IDX] & ~latch_read);
    end
  end

  // ----------------------------------------------------------------
  // Read path and alt_int
  // ----------------------------------------------------------------
  // Floating state only means something with the pull-up on
  always_comb begin
    status_val = ipei_pkg::REG_RESET;
    status_val[ipei_pkg::STAT_OPEN_BIT] = id_sync_ff & pullup_sync_ff;
    status_val[ipei_pkg::STAT_CODE_LSB +: 3] = code_ff;
    status_val[ipei_pkg::STAT_DONE_BIT] = done_ff;
    unique case (reg_addr_in)
      ipei_pkg::ID_EVENT_ENABLE_WR,
      ipei_pkg::ID_EVENT_ENABLE_SET,
      ipei_pkg::ID_EVENT_ENABLE_CLR: nxt_rdata = enable_ff;
      ipei_pkg::ID_EVENT_STATUS:     nxt_rdata = status_val;
      ipei_pkg::ID_EVENT_LATCH:      nxt_rdata = latch_ff;
      default:                       nxt_rdata = ipei_pkg::REG_RESET;
    endcase
  end

  // Read data holds until the next read; alt_int follows pending latches
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= ipei_pkg::REG_RESET;
      alt_int_out   <= 1'b0;
    end else begin
      if (reg_rd_in) begin
        reg_rdata_out <= nxt_rdata;
      end
      alt_int_out <= |(latch_ff & ipei_pkg::LATCH_MASK);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_EN_WRITE: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    reg_wr_in && reg_addr_in == ipei_pkg::ID_EVENT_ENABLE_WR |=>
    enable_ff == ($past(reg_wdata_in) & ipei_pkg::ENABLE_MASK))
    else $error("enable write did not replace value");
  AST_EN_SET: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    reg_wr_in && reg_addr_in == ipei_pkg::ID_EVENT_ENABLE_SET |=>
    enable_ff == (($past(enable_ff) | $past(reg_wdata_in))
                  & ipei_pkg::ENABLE_MASK))
    else $error("enable set did not OR data in");
  AST_EN_CLR: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    reg_wr_in && reg_addr_in == ipei_pkg::ID_EVENT_ENABLE_CLR |=>
    enable_ff == ($past(enable_ff) & ~$past(reg_wdata_in)))
    else $error("enable clear did not drop bits");
  AST_RSVD_ZERO: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    reg_rd_in |=> (reg_rdata_out & 8'h80) == 8'h00
      && ($past(reg_addr_in) != ipei_pkg::ID_EVENT_LATCH
          || (reg_rdata_out & ~ipei_pkg::LATCH_MASK) == 8'h00))
    else $error("reserved bit read as one");
  AST_OPEN_EDGE: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    ((open_rise && enable_ff[ipei_pkg::OPEN_RISE_BIT])
     || (open_fall && enable_ff[ipei_pkg::OPEN_FALL_BIT]))
    |=> latch_ff[LATCH_OPEN_IDX] ##1 alt_int_out)
    else $error("enabled ID edge not latched or reported");
  AST_DONE_TIME: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    $rose(done_ff) |-> $past(busy_ff) && !busy_ff)
    else $error("done flag set outside conversion end");
  AST_DONE_HOLD: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    done_ff && !vendor_code_read_in |=> done_ff)
    else $error("done flag cleared without vendor read");
  AST_LATCH_CLR: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    latch_read && !open_rise && !open_fall && !done_rise
    |=> latch_ff == 8'h00 ##1 !alt_int_out)
    else $error("latch not cleared by read");
  AST_DONE_LATCH: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    done_rise && done_irq_en |=> latch_ff[LATCH_DONE_IDX])
    else $error("conversion done not latched");
  AST_STATUS_RD: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    reg_rd_in && reg_addr_in == ipei_pkg::ID_EVENT_STATUS |=>
    reg_rdata_out[ipei_pkg::STAT_CODE_LSB +: 3] == $past(code_ff)
    && reg_rdata_out[ipei_pkg::STAT_DONE_BIT] == $past(done_ff))
    else $error("status read shows wrong code or done");

endmodule

`default_nettype wire

//--- tb/ipei_link_model.sv
// Link-side model that issues register accesses and owns the pull-up
`timescale 1ns/100ps
`default_nettype none
module ipei_link_model (
  // Clock
  input  wire logic       clock_in,
  // Register port toward the block
  output logic      [5:0] reg_addr_out,
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  output logic      [7:0] reg_wdata_out,
  // Pull-up control
  output logic            id_pullup_enable_out
);
  // ----------------------------------------------------------------
  // Expected read data, oldest first
  // ----------------------------------------------------------------
  logic [7:0] exp_q[$];

  // Idle bus at time zero
  initial begin
    reg_addr_out         = 6'h00;
    reg_wr_out           = 1'b0;
    reg_rd_out           = 1'b0;
    reg_wdata_out        = 8'h00;
    id_pullup_enable_out = 1'b0;
  end

  // Write strobe for one edge; data flips after so stale bytes never match
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_addr_out  <= a;
    reg_wdata_out <= d;
    reg_wr_out    <= 1'b1;
    @(posedge clock_in);
    reg_wr_out    <= 1'b0;
    reg_wdata_out <= ~d;
  endtask

  // Read strobe for one edge, expectation noted first
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge clock_in);
    reg_addr_out <= a;
    reg_rd_out   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock_in);
    reg_rd_out   <= 1'b0;
  endtask

  // Pull-up goes on before any floating edge is trusted
  task automatic set_pullup(input logic on);
    @(posedge clock_in);
    id_pullup_enable_out <= on;
  endtask
endmodule
`default_nettype wire

//--- tb/tb_id_pin_event_interrupts.sv
// Self-checking bench for the ID pin event interrupt block
`timescale 1ns/100ps
`default_nettype none
module tb_id_pin_event_interrupts;
  localparam int CONV = 8; // Short conversion keeps the run brief
  logic        clock_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [5:0]  addr;
  logic        wr, rd, pull_en, alt_int, rd_d = 1'b0;
  logic [7:0]  wdata, rdata, ex;
  logic        id_open = 1'b0, start = 1'b0, vend_en = 1'b0, vrd = 1'b0;
  logic [2:0]  code = 3'h0;
  logic [31:0] seed = 32'h4F21C082;
  int          miscompares = 0;
  int          tests_run = 0;

  always #25 clock_in = ~clock_in;

  ipei_core #(.CONV_CYCLES(CONV)) dut_u (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .id_open_in(id_open),
    .id_pullup_enable_in(pull_en), .conv_start_in(start),
    .id_resistance_code_in(code), .vendor_done_irq_en_in(vend_en),
    .vendor_code_read_in(vrd), .alt_int_out(alt_int));

  ipei_link_model link_u (
    .clock_in(clock_in), .reg_addr_out(addr), .reg_wr_out(wr),
    .reg_rd_out(rd), .reg_wdata_out(wdata),
    .id_pullup_enable_out(pull_en));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic close_out();
    if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR reg_rdata_out expected %h seen %h", e, g);
    end
  endtask

  // Level of alt_int one edge on, once that edge has settled
  task automatic chk_int(input logic e);
    @(posedge clock_in);
    #1;
    tests_run++;
    if (alt_int !== e) begin
      miscompares++;
      $display("ERROR alt_int_out expected %b seen %b", e, alt_int);
    end
  endtask

  // Read data lands one edge after the read edge; oldest note is matched
  always @(posedge clock_in) begin
    rd_d <= rd & rst_b_in;
    if (rd_d) cmp8(link_u.exp_q.pop_front(), rdata);
  end

  // Watchdog far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clock_in);
    miscompares++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge clock_in);
    rst_b_in <= 1'b1;
    // Reset values, aliases and an unmapped address all read zero
    for (int i = 0; i < 6; i++)
      link_u.rd(i < 5 ? 6'h1D + 6'(i) : 6'h3F, 8'h00);
    link_u.wr(ipei_pkg::ID_EVENT_ENABLE_WR, 8'hFF);
    link_u.rd(ipei_pkg::ID_EVENT_ENABLE_CLR, 8'h23);
    link_u.wr(ipei_pkg::ID_EVENT_ENABLE_CLR, 8'h22);
    link_u.rd(ipei_pkg::ID_EVENT_ENABLE_WR, 8'h01);
    link_u.wr(ipei_pkg::ID_EVENT_ENABLE_SET, 8'h20);
    link_u.rd(ipei_pkg::ID_EVENT_ENABLE_SET, 8'h21);
    link_u.wr(ipei_pkg::ID_EVENT_STATUS, 8'hFF);
    link_u.wr(ipei_pkg::ID_EVENT_LATCH, 8'hFF);
    link_u.rd(ipei_pkg::ID_EVENT_STATUS, 8'h00);
    link_u.rd(ipei_pkg::ID_EVENT_LATCH, 8'h00);
    // Floating edge with rise enabled, then fall with fall masked
    link_u.set_pullup(1'b1);
    @(posedge clock_in) id_open <= 1'b1;
    repeat (5) @(posedge clock_in);
    chk_int(1'b1);
    link_u.rd(ipei_pkg::ID_EVENT_STATUS, 8'h01);
    link_u.rd(ipei_pkg::ID_EVENT_LATCH, 8'h01);
    @(posedge clock_in);
    chk_int(1'b0);
    @(posedge clock_in) id_open <= 1'b0;
    repeat (5) @(posedge clock_in);
    chk_int(1'b0);
    // Swap enables: rise masked, fall armed
    link_u.wr(ipei_pkg::ID_EVENT_ENABLE_WR, 8'h22);
    @(posedge clock_in) id_open <= 1'b1;
    repeat (5) @(posedge clock_in);
    link_u.rd(ipei_pkg::ID_EVENT_LATCH, 8'h00);
    @(posedge clock_in) id_open <= 1'b0;
    repeat (5) @(posedge clock_in);
    chk_int(1'b1);
    link_u.rd(ipei_pkg::ID_EVENT_LATCH, 8'h01);
    // Every result code, irq enable from register bit or random vendor bit
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      link_u.wr(ipei_pkg::ID_EVENT_ENABLE_WR, {2'b00, i[0], 5'h00});
      @(posedge clock_in);
      code    <= i[2:0];
      vend_en <= seed[0];
      start   <= 1'b1;
      @(posedge clock_in) start <= 1'b0;
      repeat (CONV + 4) @(posedge clock_in);
      ex = {2'b01, i[2:0], 3'b000};
      link_u.rd(ipei_pkg::ID_EVENT_STATUS, ex);
      link_u.rd(ipei_pkg::ID_EVENT_STATUS, ex);
      chk_int(i[0] | seed[0]);
      link_u.rd(ipei_pkg::ID_EVENT_LATCH,
                (i[0] | seed[0]) ? 8'h08 : 8'h00);
      @(posedge clock_in) vrd <= 1'b1;
      @(posedge clock_in) vrd <= 1'b0;
      link_u.rd(ipei_pkg::ID_EVENT_STATUS, {2'b00, i[2:0], 3'b000});
    end
    repeat (3) @(posedge clock_in);
    close_out();
  end
endmodule
`default_nettype wire
